// ### verilog/rdm_defs.svh
`ifndef RDM_DEFS_SVH
`define RDM_DEFS_SVH

`define RDM_ADDR_W 32
`define RDM_DATA_W 32
`define RDM_REG_AW 8
`define RDM_WORD_BYTES 32'h4
`define RDM_FIFO_DEPTH 5'h08

`define RDM_OFF_CTRL 8'h00
`define RDM_OFF_START 8'h04
`define RDM_OFF_LEN 8'h08
`define RDM_OFF_STATUS 8'h0C
`define RDM_OFF_REMAIN 8'h10
`define RDM_OFF_IRQ_STAT 8'h14
`define RDM_OFF_IRQ_MASK 8'h18

`define RDM_CTRL_LAUNCH 0
`define RDM_IRQ_DONE 0
`define RDM_IRQ_IGNORED 1
`define RDM_STAT_BUSY 0
`define RDM_STAT_DONE 1

`define RDM_RST_WORD 32'h0000_0000
`define RDM_RST_IRQ 2'h0

`endif

// ### verilog/rdm_pkg.sv
`include "rdm_defs.svh"

package rdm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_DRAIN = 2'b10
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic rd;
        logic [31:0] addr;
        logic [31:0] len;
        logic [31:0] start;
        logic [31:0] len_cfg;
        logic done;
        logic [3:0] outst;
        logic [3:0] fill;
        logic [2:0] wptr;
        logic [2:0] rptr;
        logic [7:0][31:0] mem;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
    } state_t;

endpackage

// ### verilog/pipelined_read_master_fifo.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_defs.svh"

module pipelined_read_master_fifo
(
    input wire logic clk_i, // 10 MHz clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic [7:0] reg_addr_i, // register byte address
    input wire logic [31:0] reg_wdata_i, // register write data
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    output logic [31:0] reg_rdata_o, // read data, cycle after strobe
    output logic irq_o, // level interrupt
    output logic [31:0] mem_addr_o, // read address
    output logic [3:0] mem_byteen_o, // byte enables
    output logic mem_read_o, // read request
    input wire logic mem_stall_i, // stall from interconnect
    input wire logic [31:0] mem_rdata_i, // returned read data
    input wire logic mem_rvalid_i, // returned data valid
    output logic out_valid_o, // fifo word available
    output logic [31:0] out_data_o, // fifo head word
    input wire logic out_ready_i, // consumer takes head word
    output logic busy_o, // transfer in progress
    output logic done_o // all reads returned
);
    import rdm_pkg::*;

    // ****************************************
    // register decode
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    state_t s_q;
    state_t s_d;
    logic posted;
    logic push;
    logic pop;
    logic launch_wr;
    logic accept;
    logic ignored;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [4:0] room_sum;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        posted = s_q.rd & ~mem_stall_i;
        push = mem_rvalid_i;
        pop = (s_q.fill != 4'h0) & out_ready_i;
        launch_wr = reg_wr_i & hit(reg_addr_i, `RDM_OFF_CTRL) & reg_wdata_i[`RDM_CTRL_LAUNCH];
        accept = launch_wr & (s_q.phase == ST_IDLE);
        ignored = launch_wr & (s_q.phase != ST_IDLE);
        irq_set = 2'h0;
        irq_clr = 2'h0;

        // configuration writes
        if (reg_wr_i)
        begin
            if (hit(reg_addr_i, `RDM_OFF_START))
            begin
                s_d.start = reg_wdata_i;
            end
            if (hit(reg_addr_i, `RDM_OFF_LEN))
            begin
                s_d.len_cfg = reg_wdata_i;
            end
            if (hit(reg_addr_i, `RDM_OFF_IRQ_MASK))
            begin
                s_d.irq_mask = reg_wdata_i[1:0];
            end
            if (hit(reg_addr_i, `RDM_OFF_IRQ_STAT))
            begin
                irq_clr = reg_wdata_i[1:0];
            end
        end

        // returned words land in the fifo
        if (push)
        begin
            s_d.mem[s_q.wptr] = mem_rdata_i;
            s_d.wptr = s_q.wptr + 3'h1;
        end
        if (pop)
        begin
            s_d.rptr = s_q.rptr + 3'h1;
        end
        case ({push, pop})
            2'b10: s_d.fill = s_q.fill + 4'h1;
            2'b01: s_d.fill = s_q.fill - 4'h1;
            default: s_d.fill = s_q.fill;
        endcase

        // outstanding read tracking
        case ({posted, push})
            2'b10: s_d.outst = s_q.outst + 4'h1;
            2'b01: s_d.outst = s_q.outst - 4'h1;
            default: s_d.outst = s_q.outst;
        endcase

        // address and length walk
        if (accept)
        begin
            s_d.addr = {s_q.start[31:2], 2'b00};
            s_d.len = s_q.len_cfg;
        end
        else if (posted && (s_q.len != 32'h0))
        begin
            s_d.addr = s_q.addr + `RDM_WORD_BYTES;
            s_d.len = s_q.len - `RDM_WORD_BYTES;
        end

        // transfer phase
        case (s_q.phase)
            ST_IDLE:
            begin
                if (accept)
                begin
                    s_d.phase = ST_ISSUE;
                    s_d.done = 1'b0;
                end
            end
            ST_ISSUE:
            begin
                if ((s_q.len == 32'h0) && !s_q.rd)
                begin
                    s_d.phase = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                // last word may still be in flight after length hits zero
                if (s_q.outst == 4'h0)
                begin
                    s_d.phase = ST_IDLE;
                    s_d.done = 1'b1;
                    irq_set[`RDM_IRQ_DONE] = 1'b1;
                end
            end
            default:
            begin
                s_d.phase = ST_IDLE;
            end
        endcase

        // read request: a stalled request must not move
        room_sum = {1'b0, s_d.fill} + {1'b0, s_d.outst};
        if (s_q.rd && mem_stall_i)
        begin
            s_d.rd = 1'b1;
        end
        else
        begin
            // space counts words held plus words still owed
            s_d.rd = (s_d.phase == ST_ISSUE) && (s_d.len != 32'h0)
                && (room_sum < `RDM_FIFO_DEPTH);
        end

        // interrupts: a new event beats a clear in the same cycle
        irq_set[`RDM_IRQ_IGNORED] = ignored;
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

        // read back
        s_d.rdata = `RDM_RST_WORD;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RDM_OFF_START: s_d.rdata = s_q.start;
                `RDM_OFF_LEN: s_d.rdata = s_q.len_cfg;
                `RDM_OFF_STATUS: s_d.rdata = {20'h0, s_q.fill, s_q.outst, 2'h0,
                    s_q.done, s_q.phase != ST_IDLE};
                `RDM_OFF_REMAIN: s_d.rdata = s_q.len;
                `RDM_OFF_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
                `RDM_OFF_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
                default: s_d.rdata = `RDM_RST_WORD;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign mem_addr_o = s_q.addr;
    assign mem_byteen_o = 4'hF;
    assign mem_read_o = s_q.rd;
    assign out_valid_o = (s_q.fill != 4'h0);
    assign out_data_o = s_q.mem[s_q.rptr];
    assign reg_rdata_o = s_q.rdata;
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
    assign busy_o = (s_q.phase != ST_IDLE);
    assign done_o = s_q.done;

    // ****************************************
    // checks
    // ****************************************
    stall_hold_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_read_o && mem_stall_i |=> mem_read_o && $stable(mem_addr_o))
        else $error("stalled read changed");

    full_word_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_read_o |-> mem_byteen_o == 4'hF && mem_addr_o[1:0] == 2'b00)
        else $error("read not full aligned word");

    post_step_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        posted && s_q.len != 32'h0 |=> mem_addr_o == $past(mem_addr_o) + 32'h4
            && s_q.len == $past(s_q.len) - 32'h4)
        else $error("posted read did not step by four");

    no_post_hold_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !posted && busy_o |=> $stable(s_q.len) && $stable(mem_addr_o))
        else $error("length moved without a post");

    launch_load_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        accept |=> s_q.len == $past(s_q.len_cfg) && busy_o && !done_o)
        else $error("launch did not load");

    launch_issue_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        accept && s_q.len_cfg != 32'h0 && s_q.fill == 4'h0 && s_q.outst == 4'h0
            |=> mem_read_o)
        else $error("no read after launch");

    outst_up_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        posted && !mem_rvalid_i |=> s_q.outst == $past(s_q.outst) + 4'h1)
        else $error("outstanding count missed increment");

    outst_down_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !posted && mem_rvalid_i |=> s_q.outst == $past(s_q.outst) - 4'h1)
        else $error("outstanding count missed decrement");

    space_limit_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ({1'b0, s_q.fill} + {1'b0, s_q.outst}) <= `RDM_FIFO_DEPTH)
        else $error("outstanding reads exceed fifo space");

    no_overflow_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_rvalid_i |-> s_q.fill < 4'h8)
        else $error("fifo overflow");

    done_gate_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(done_o) |-> s_q.len == 32'h0 && s_q.outst == 4'h0 && !mem_read_o)
        else $error("done before last word");

    busy_ignore_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ignored |=> s_q.irq_stat[1] && $stable(s_q.done))
        else $error("launch while busy not ignored");

    // back to back posting is what hides the slave latency
    issue_rate_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        posted && s_q.len != 32'h4 && (({1'b0, s_q.fill} + {1'b0, s_q.outst}) + 5'h01) < `RDM_FIFO_DEPTH
            |=> mem_read_o)
        else $error("read gap while room left");

    fill_stop_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        posted && !pop && ({1'b0, s_q.fill} + {1'b0, s_q.outst}) == 5'h07 |=> !mem_read_o)
        else $error("read issued into a full fifo");

    room_held_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_read_o |-> ({1'b0, s_q.fill} + {1'b0, s_q.outst}) < `RDM_FIFO_DEPTH)
        else $error("read pending without fifo room");

    drain_wait_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        s_q.phase == ST_DRAIN && s_q.outst != 4'h0 |=> !done_o)
        else $error("done while reads outstanding");

    done_sticky_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        done_o && !accept |=> done_o)
        else $error("done dropped without a launch");

    start_align_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        accept |=> mem_addr_o == ($past(s_q.start) & 32'hFFFF_FFFC))
        else $error("launch address not loaded aligned");

    idle_quiet_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !busy_o |-> !mem_read_o)
        else $error("read outside a transfer");

    len_nonzero_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_read_o |-> s_q.len != 32'h0)
        else $error("read with nothing left");

    fifo_head_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        mem_rvalid_i && !out_valid_o |=> out_valid_o && out_data_o == $past(mem_rdata_i))
        else $error("returned word not at fifo head");

    outst_hold_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        posted == mem_rvalid_i |=> $stable(s_q.outst))
        else $error("outstanding count moved");

    done_event_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(done_o) |-> s_q.irq_stat[`RDM_IRQ_DONE])
        else $error("done event not flagged");

    ignore_keep_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ignored && !posted |=> $stable(s_q.len) && $stable(mem_addr_o))
        else $error("ignored launch reloaded the walk");

    pop_step_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        pop && !push |=> s_q.fill == $past(s_q.fill) - 4'h1)
        else $error("fifo fill missed a pop");

endmodule

`default_nettype wire

// ### bench/mem_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// far side: slave behind the interconnect
// ****************
module mem_slave_model
(
    input wire logic clk_i, // bench clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic [31:0] addr_i, // read address
    input wire logic read_i, // read request
    input wire logic stall_en_i, // act as a non-pipelined slave
    input wire logic [3:0] lat_i, // cycles from post to data
    output logic stall_o, // stall toward master
    output logic [31:0] rdata_o, // returned word
    output logic rvalid_o // returned word valid
);
    logic [31:0] pend_q[$];
    int due_q[$];
    int cyc;
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stall_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            cyc = 0;
            pend_q.delete();
            due_q.delete();
        end
        else
        begin
            if (pend_q.size() != 0 && due_q[0] <= cyc)
            begin
                rvalid_o <= 1'b1;
                rdata_o <= pend_q.pop_front() ^ 32'h5A5A_0000;
                void'(due_q.pop_front());
            end
            else
            begin
                rvalid_o <= 1'b0;
                rdata_o <= ~rdata_o; // no stale word between answers
            end
            if (read_i && !stall_o)
            begin
                pend_q.push_back(addr_i);
                due_q.push_back(cyc + lat_i);
            end
            stall_o <= stall_en_i && pend_q.size() != 0;
            cyc++;
        end
    end
endmodule
`default_nettype wire

// ### bench/test_pipelined_read_master_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// stimulus and checks
// ****************
module test_pipelined_read_master_fifo;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic out_ready = 1'b0;
    logic stall_en = 1'b0;
    logic [3:0] lat = 4'h2;
    logic [31:0] reg_rdata, mem_addr, mem_rdata, out_data, post_addr, pop_addr, prev_addr;
    logic [3:0] mem_byteen;
    logic irq, mem_read, mem_stall, mem_rvalid, out_valid, busy, done;
    logic prev_wait = 1'b0;
    int errors = 0;
    int compares = 0;
    int outst = 0;
    int fill = 0;
    int nposts = 0;
    int nwords = 0;
    always #50 clk_i = ~clk_i;
    pipelined_read_master_fifo uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .irq_o(irq), .mem_addr_o(mem_addr), .mem_byteen_o(mem_byteen), .mem_read_o(mem_read),
        .mem_stall_i(mem_stall), .mem_rdata_i(mem_rdata), .mem_rvalid_i(mem_rvalid),
        .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(out_ready), .busy_o(busy),
        .done_o(done));
    mem_slave_model partner (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(mem_addr), .read_i(mem_read),
        .stall_en_i(stall_en), .lat_i(lat), .stall_o(mem_stall), .rdata_o(mem_rdata), .rvalid_o(mem_rvalid));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        @(negedge clk_i);
        check(name, exp, reg_rdata);
    endtask
    task automatic launch(input logic [31:0] s, input logic [31:0] base, input logic [31:0] len, input int w);
        reg_write(8'h04, s);
        reg_write(8'h08, len);
        reg_write(8'h00, 32'h1);
        nposts = 0;
        nwords = w;
        post_addr = base;
        pop_addr = base;
        @(negedge clk_i);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clk_i);
        if (done !== 1'b1)
        begin
            errors++;
            complete_run();
        end
    endtask
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************
    // bus monitor, sampled mid-cycle where all is settled
    // ****************
    always @(negedge clk_i)
    begin
        if (arst_n_i)
        begin
            if (prev_wait)
            begin
                check("held read", 32'h1, {31'h0, mem_read});
                check("held addr", prev_addr, mem_addr);
            end
            if (mem_read && !mem_stall)
            begin
                check("post addr", post_addr, mem_addr);
                post_addr = post_addr + 32'h4;
                nposts++;
            end
            check("byte enables", 32'hF, {28'h0, mem_byteen});
            check("fifo valid", {31'h0, fill != 0}, {31'h0, out_valid});
            check("room", 32'h1, {31'h0, outst + fill <= 8});
            if (done && !reg_wr)
            begin
                check("posts at done", nwords, nposts);
                check("pending at done", 32'h0, outst);
            end
            outst += (mem_read && !mem_stall) - mem_rvalid;
            fill += mem_rvalid - (out_valid && out_ready);
            if (out_valid && out_ready)
            begin
                check("out word", pop_addr ^ 32'h5A5A_0000, out_data);
                pop_addr = pop_addr + 32'h4;
            end
            prev_wait = mem_read && mem_stall;
            prev_addr = mem_addr;
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        reg_read(8'h04, 32'h0, "start reset");
        reg_read(8'h18, 32'h0, "mask reset");
        reg_read(8'h1C, 32'h0, "unmapped");
        reg_write(8'h18, 32'h3);
        // consumer stalled: twelve words cannot all fit
        launch(32'h100, 32'h100, 32'h30, 12);
        repeat (30) @(negedge clk_i);
        check("stopped", 32'h1, {31'h0, nposts <= 8 && busy === 1'b1});
        reg_read(8'h0C, 32'h801, "status full");
        reg_read(8'h10, 32'h10, "remain stopped");
        reg_read(8'h08, 32'h30, "length cfg");
        reg_write(8'h00, 32'h1);
        out_ready <= 1'b1;
        wait_done();
        reg_read(8'h10, 32'h0, "remain");
        check("irq", 32'h1, {31'h0, irq});
        reg_read(8'h14, 32'h3, "irq status");
        reg_write(8'h14, 32'h3);
        reg_read(8'h14, 32'h0, "irq cleared");
        check("irq low", 32'h0, {31'h0, irq});
        reg_write(8'h18, 32'h0);
        stall_en <= 1'b1;
        lat <= 4'h5;
        launch(32'h203, 32'h200, 32'h10, 4);
        check("done cleared", 32'h0, {31'h0, done});
        wait_done();
        check("masked irq", 32'h0, {31'h0, irq});
        reg_read(8'h14, 32'h1, "done event");
        stall_en <= 1'b0;
        launch(32'h300, 32'h300, 32'h0, 0);
        wait_done();
        reg_read(8'h0C, 32'h2, "status done");
        complete_run();
    end
endmodule
`default_nettype wire
